// file: wdt_pkg.sv
package wdt_pkg;
  // I/O decode bases, selected by the base strap
  localparam logic [9:0] BASE_0 = 10'h190;
  localparam logic [9:0] BASE_1 = 10'h290;
  localparam logic [9:0] BASE_2 = 10'h390;
  localparam int CTRL_WIDTH = 8;
  localparam int ENABLE_BIT = 0;
  localparam int REFRESH_BIT = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int TIMEOUT_LONG_MS = 1600;
  localparam int TIMEOUT_SHORT_MS = 100;
  localparam int TIMEOUT_LONG_CYC = TIMEOUT_LONG_MS * (CLK_HZ / 1000);
  localparam int TIMEOUT_SHORT_CYC = TIMEOUT_SHORT_MS * (CLK_HZ / 1000);
  localparam int PULSE_CYC = 16;
  localparam int CNT_W = 27;
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_RUN = 3'b010,
    ST_FIRE = 3'b100
  } wdt_state_t;
endpackage

// file: wdt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface wdt_if;
  logic run;
  logic kick;
  logic expired;
  modport ctrl (output run, output kick, input expired);
  modport cnt (input run, input kick, output expired);
endinterface
`default_nettype wire

// file: wdt_counter.sv
`timescale 1ns/1ps
`default_nettype none
module wdt_counter #(
  parameter int CNT_W = 27
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [CNT_W-1:0] limit,
  wdt_if.cnt ctl
);
  logic [CNT_W-1:0] count_reg;
  logic expired_reg;
  wire logic at_limit = (count_reg >= limit - 1'b1);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
      expired_reg <= 1'b0;
    end else if (!ctl.run || ctl.kick) begin
      count_reg <= '0;
      expired_reg <= 1'b0;
    end else if (!expired_reg) begin
      count_reg <= count_reg + 1'b1;
      expired_reg <= at_limit;
    end
  end
  assign ctl.expired = expired_reg;
endmodule // wdt_counter
`default_nettype wire

// file: io_mapped_watchdog_timer.sv
`timescale 1ns/1ps
`default_nettype none
module io_mapped_watchdog_timer
  import wdt_pkg::*;
#(
  parameter int LONG_CYC = wdt_pkg::TIMEOUT_LONG_CYC,
  parameter int SHORT_CYC = wdt_pkg::TIMEOUT_SHORT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // I/O read and write port
  input wire logic [9:0] io_addr,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  input wire logic io_rd,
  output logic [7:0] io_rdata,
  output logic io_sel,
  // Straps and configuration
  input wire logic [1:0] base_select_strap,
  input wire logic watchdog_permit_strap,
  input wire logic short_timeout,
  // Status and reset out
  output logic wdt_active,
  output logic wdt_reset
);
  import wdt_pkg::*;

  logic rst_sync1_reg, rst_sync2_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end
  wire logic srst_n = rst_sync2_reg;

  // Strap code 3 falls back to the first base
  wire logic [9:0] base_addr =
    (base_select_strap == 2'd1) ? BASE_1 :
    (base_select_strap == 2'd2) ? BASE_2 : BASE_0;
  wire logic hit = (io_addr == base_addr);
  wire logic wr_hit = io_wr && hit;
  wire logic rd_hit = io_rd && hit;

  logic [7:0] ctrl_reg;
  wdt_state_t state_reg, state_next;
  logic [$clog2(PULSE_CYC+1)-1:0] pulse_reg;
  logic wdt_reset_reg, active_reg, sel_reg;
  logic [7:0] rdata_reg;

  wire logic refresh_edge = wr_hit &&
    (io_wdata[REFRESH_BIT] != ctrl_reg[REFRESH_BIT]);
  wire logic enable_req = wr_hit && io_wdata[ENABLE_BIT];
  wire logic permit = watchdog_permit_strap;
  wire logic [CNT_W-1:0] limit = short_timeout ?
    CNT_W'(SHORT_CYC) : CNT_W'(LONG_CYC);

  wdt_if cif ();
  assign cif.run = (state_reg == ST_RUN) && permit;
  assign cif.kick = refresh_edge;
  // Counter clears itself whenever run drops, so no stale count survives
  wdt_counter #(.CNT_W(CNT_W)) u_cnt (
    .clk(clk),
    .rst_n(srst_n),
    .limit(limit),
    .ctl(cif)
  );

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_OFF: if (enable_req && permit) state_next = ST_RUN;
      ST_RUN: begin
        if (!permit) state_next = ST_OFF;
        else if (cif.expired) state_next = ST_FIRE;
      end
      ST_FIRE: if (pulse_reg == 1) state_next = ST_OFF;
      default: state_next = ST_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      state_reg <= ST_OFF;
      ctrl_reg <= CTRL_RESET;
    end else begin
      state_reg <= state_next;
      // Timeout beats a same-cycle write so the enable really clears
      if (state_next == ST_FIRE && state_reg == ST_RUN)
        ctrl_reg[ENABLE_BIT] <= 1'b0;
      else if (wr_hit)
        ctrl_reg <= io_wdata;
    end
  end

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      pulse_reg <= '0;
      wdt_reset_reg <= 1'b0;
    end else if (state_reg == ST_RUN && state_next == ST_FIRE) begin
      pulse_reg <= ($clog2(PULSE_CYC+1))'(PULSE_CYC);
      wdt_reset_reg <= 1'b1;
    end else if (pulse_reg != 0) begin
      pulse_reg <= pulse_reg - 1'b1;
      wdt_reset_reg <= (pulse_reg != 1);
    end
  end

  // Readback is a courtesy; software should keep its own copy
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      active_reg <= 1'b0;
      sel_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      active_reg <= (state_next == ST_RUN);
      sel_reg <= rd_hit;
      rdata_reg <= rd_hit ? ctrl_reg : 8'h00;
    end
  end

  assign io_rdata = rdata_reg;
  assign io_sel = sel_reg;
  assign wdt_active = active_reg;
  assign wdt_reset = wdt_reset_reg;

  a_reset_idle: assert property (@(posedge clk)
    $rose(srst_n) |-> !wdt_reset && !wdt_active)
    else $error("watchdog not idle after reset");
  a_permit_off: assert property (@(posedge clk) disable iff (!srst_n)
    !watchdog_permit_strap |=> !wdt_active)
    else $error("watchdog active without permit");
  a_enable_write: assert property (@(posedge clk) disable iff (!srst_n)
    (state_reg == ST_OFF && enable_req && permit) |=> wdt_active)
    else $error("enable write ignored");
  sequence s_fire;
    $rose(wdt_reset) ##1 wdt_reset [*8];
  endsequence
  a_pulse_len: assert property (@(posedge clk) disable iff (!srst_n)
    $rose(wdt_reset) |-> s_fire)
    else $error("reset pulse too short");
  a_pulse_end: assert property (@(posedge clk) disable iff (!srst_n)
    $rose(wdt_reset) |-> ##[1:40] !wdt_reset && state_reg == ST_OFF)
    else $error("reset pulse did not end");
  a_fire_cause: assert property (@(posedge clk) disable iff (!srst_n)
    $rose(wdt_reset) |-> $past(cif.expired))
    else $error("reset pulse without expiry");
  a_kick_clear: assert property (@(posedge clk) disable iff (!srst_n)
    (refresh_edge && cif.run) |=> !cif.expired)
    else $error("refresh did not restart count");
  a_addr_decode: assert property (@(posedge clk) disable iff (!srst_n)
    (io_wr && !hit) |=> ctrl_reg == $past(ctrl_reg))
    else $error("write outside decode stored");

  // Status flop tracks the state register one to one
  a_act_state: assert property (@(posedge clk) disable iff (!srst_n)
    wdt_active == (state_reg == ST_RUN))
    else $error("active flag out of step with state");
  a_rst_quiet: assert property (@(posedge clk) disable iff (!srst_n)
    wdt_reset |-> !wdt_active)
    else $error("active during reset pulse");
  a_fire_off: assert property (@(posedge clk) disable iff (!srst_n)
    $fell(wdt_reset) |-> state_reg == ST_OFF)
    else $error("pulse ended without disabling");
  a_off_calm: assert property (@(posedge clk) disable iff (!srst_n)
    (state_reg == ST_OFF) |=> !$rose(wdt_reset))
    else $error("reset pulse while disabled");
  a_exp_fire: assert property (@(posedge clk) disable iff (!srst_n)
    (state_reg == ST_RUN && cif.expired && permit) |=> $rose(wdt_reset))
    else $error("expiry gave no reset pulse");
  sequence s_quiet;
    !wdt_reset [*8];
  endsequence
  a_gap_after: assert property (@(posedge clk) disable iff (!srst_n)
    $fell(wdt_reset) |-> s_quiet)
    else $error("reset pulse retriggered");
  // Limit follows the static timeout select
  a_lim_short: assert property (@(posedge clk) disable iff (!srst_n)
    short_timeout |-> limit == CNT_W'(SHORT_CYC))
    else $error("short limit not selected");
  a_lim_long: assert property (@(posedge clk) disable iff (!srst_n)
    !short_timeout |-> limit == CNT_W'(LONG_CYC))
    else $error("long limit not selected");
  a_no_kick: assert property (@(posedge clk) disable iff (!srst_n)
    (wr_hit && io_wdata[REFRESH_BIT] == ctrl_reg[REFRESH_BIT]) |-> !cif.kick)
    else $error("unchanged refresh bit kicked");
  a_cnt_max: assert property (@(posedge clk) disable iff (!srst_n)
    cif.run |-> u_cnt.count_reg <= limit)
    else $error("count ran past limit");
  a_perm_run: assert property (@(posedge clk) disable iff (!srst_n)
    !permit |-> !cif.run)
    else $error("counter runs without permit");
  // Reset release ordering through the two flops
  a_sync_ord: assert property (@(posedge clk)
    !rst_sync1_reg |-> !srst_n)
    else $error("reset released out of order");
  // Read side
  a_rd_sel: assert property (@(posedge clk) disable iff (!srst_n)
    rd_hit |=> io_sel)
    else $error("read hit not answered");
  a_rd_idle: assert property (@(posedge clk) disable iff (!srst_n)
    !rd_hit |=> !io_sel)
    else $error("select without read hit");
  a_rd_zero: assert property (@(posedge clk) disable iff (!srst_n)
    !io_sel |-> io_rdata == 8'h00)
    else $error("read data not zero when idle");
endmodule // io_mapped_watchdog_timer
`default_nettype wire

// file: host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Bus
  input wire logic clk,
  output logic [9:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata
);
  logic [7:0] shadow = 8'h00;
  initial begin
    io_addr = 10'h000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  task automatic rd(input logic [9:0] a);
    @(negedge clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(negedge clk);
    io_rd <= 1'b0;
    io_addr <= ~a;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    shadow = d;
    @(negedge clk);
    io_wr <= 1'b0;
    io_addr <= ~a;
    io_wdata <= ~d;
  endtask
  // Flips the kept copy, since the register cannot be trusted on readback
  task automatic kick(input logic [9:0] a);
    wr(a, shadow ^ 8'h02);
  endtask
endmodule // host_model
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import wdt_pkg::*;
  localparam int L = 200;
  localparam int S = 50;
  logic clk = 1'b0, rst_n, wr, permit, short_t, active, wreset;
  logic [9:0] addr;
  logic [7:0] wdata;
  logic [1:0] strap;
  logic rd, sel;
  logic [7:0] rdata;
  logic [8:0] rexp;
  logic [8:0] rd_notes[$];
  int fails = 0, checks = 0, cyc = 0, width = 0, d;
  int notes[$];
  logic [9:0] bases[4] = '{10'h190, 10'h290, 10'h390, 10'h190};
  initial begin
    forever #10 clk = ~clk;
  end
  host_model host (.clk(clk), .io_addr(addr), .io_wr(wr), .io_rd(rd),
    .io_wdata(wdata));
  io_mapped_watchdog_timer #(.LONG_CYC(L), .SHORT_CYC(S))
    u_io_mapped_watchdog_timer (.clk(clk), .rst_n(rst_n), .io_addr(addr),
    .io_wr(wr), .io_wdata(wdata), .io_rd(rd), .io_rdata(rdata), .io_sel(sel),
    .base_select_strap(strap), .watchdog_permit_strap(permit),
    .short_timeout(short_t), .wdt_active(active), .wdt_reset(wreset));
  task automatic check(input logic [31:0] seen, exp, input string n);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %0h seen %0h", n, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    idle(10);
    rst_n = 1'b1;
    idle(3);
  endtask
  always @(posedge clk) cyc <= cyc + 1;
  // A pulse with no note pending is a spurious timeout
  always @(negedge clk) begin
    if (wreset === 1'b1) begin
      if (width == 0) begin
        d = notes.size() > 0 ? cyc - notes.pop_front() : -99;
        check(d >= 0 && d <= 3, 1'b1, "fire_time");
        check(active, 1'b0, "fire_active");
      end
      width++;
    end else if (width != 0) begin
      check(width, PULSE_CYC, "pulse_len");
      width = 0;
    end
    if (sel === 1'b1) begin
      rexp = rd_notes.size() > 0 ? rd_notes.pop_front() : 9'h100;
      check(rdata, rexp, "readback");
    end
  end
  initial begin
    rst_n = 1'b0;
    strap = 2'd0;
    permit = 1'b1;
    short_t = 1'b1;
    void'($urandom(23086));
    do_reset();
    idle(S + 40);
    check(active, 1'b0, "idle");
    for (int s = 0; s < 4; s++) begin
      strap = 2'(s);
      host.wr(bases[(s + 1) % 3], 8'($urandom) | 8'h01);
      idle(3);
      check(active, 1'b0, "wrong_base");
      host.wr(bases[s], 8'h01);
      notes.push_back(cyc + S);
      idle(1);
      check(active, 1'b1, "enable");
      idle(S + 30);
      check(active, 1'b0, "after_fire");
    end
    short_t = 1'b0;
    strap = 2'd1;
    host.wr(10'h290, 8'h01);
    rd_notes.push_back({1'b0, host.shadow});
    host.rd(10'h290);
    host.rd(10'h390);
    repeat (4) begin
      idle(100 + $urandom % 80);
      host.kick(10'h290);
    end
    notes.push_back(cyc + L);
    idle(150);
    host.wr(10'h290, host.shadow);
    idle(L);
    check(active, 1'b0, "long_fire");
    host.wr(10'h290, 8'h01);
    idle(20);
    do_reset();
    check(active, 1'b0, "reset_mid");
    idle(L + 40);
    short_t = 1'b1;
    host.wr(10'h290, 8'h01);
    idle(5);
    check(active, 1'b1, "permit_run");
    permit = 1'b0;
    idle(2);
    check(active, 1'b0, "permit_drop");
    idle(S + 40);
    host.wr(10'h290, 8'h01);
    idle(3);
    check(active, 1'b0, "permit_low");
    idle(S + 40);
    check(notes.size() + rd_notes.size(), 0, "pending");
    give_verdict();
  end
  initial begin
    #400000;
    fails++;
    give_verdict();
  end
endmodule // tb
`default_nettype wire
